// ==== core/sast_defs.vh ====
`ifndef SAST_DEFS_VH
`define SAST_DEFS_VH

// ----------------------------------------
// Word length codes
// ----------------------------------------
`define SAST_WL_7 2'h0
`define SAST_WL_8 2'h1
`define SAST_WL_9 2'h2

// ----------------------------------------
// Bit timing in rate ticks
// ----------------------------------------
`define SAST_TPB_ASYNC 4'hF
`define SAST_TPB_SYNC 4'h7
`define SAST_HALF_ASYNC 4'h7
`define SAST_HALF_SYNC 4'h3
`define SAST_SIR_PULSE 4'h3
`define SAST_SIR_HOLD 5'h10

// ----------------------------------------
// Queues
// ----------------------------------------
`define SAST_DEPTH 4'h8
`define SAST_RTS_LIMIT 4'h7

// ----------------------------------------
// Status flag positions
// ----------------------------------------
`define SAST_SF_PAR 0
`define SAST_SF_FRM 1
`define SAST_SF_OVR 2
`define SAST_SF_BRK 3
`define SAST_SF_TMO 4
`define SAST_SF_TXE 5
`define SAST_SF_RXT 6
`define SAST_SF_BSY 7

`endif

// ==== core/sast_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sast_defs.vh"

module sast_fifo (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire push_i,
	input wire [8:0] din_i,
	input wire pop_i,
	output reg [8:0] dout_q,
	output reg [3:0] count_q,
	output reg full_q,
	output reg empty_q
);
	reg [8:0] mem [0:7];
	reg [2:0] wp_q;
	reg [2:0] rp_q;
	wire do_push = push_i && !full_q;
	wire do_pop = pop_i && !empty_q;
	wire [2:0] rp_n = rp_q + {2'h0, do_pop};
	wire [3:0] cnt_n = count_q + {3'h0, do_push} - {3'h0, do_pop};

	always @(posedge clk_sys_i) begin
		if (do_push) begin
			mem[wp_q] <= din_i;
		end
	end

	// ----------------------------------------
	// Pointers and registered head word
	// ----------------------------------------
	// Bypass keeps the head valid when writing into an empty queue
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wp_q <= 3'h0;
			rp_q <= 3'h0;
			count_q <= 4'h0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
			dout_q <= 9'h000;
		end else begin
			wp_q <= wp_q + {2'h0, do_push};
			rp_q <= rp_n;
			count_q <= cnt_n;
			full_q <= (cnt_n == `SAST_DEPTH);
			empty_q <= (cnt_n == 4'h0);
			dout_q <= (do_push && wp_q == rp_n) ? din_i : mem[rp_n];
		end
	end
endmodule

`default_nettype wire

// ==== core/sast_sir.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sast_defs.vh"

module sast_sir (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire tick_i,
	input wire tx_bit_i,
	input wire [3:0] tx_phase_i,
	input wire sir_rx_i,
	output reg sir_tx_q,
	output reg sir_rx_q
);
	reg [4:0] hold_q;

	// ----------------------------------------
	// Encoder and decoder
	// ----------------------------------------
	// A zero bit becomes a short high pulse; a pulse is stretched back to a bit
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sir_tx_q <= 1'b0;
			sir_rx_q <= 1'b1;
			hold_q <= 5'h00;
		end else begin
			sir_tx_q <= !tx_bit_i && (tx_phase_i < `SAST_SIR_PULSE);
			if (sir_rx_i) begin
				hold_q <= `SAST_SIR_HOLD;
			end else if (tick_i && hold_q != 5'h00) begin
				hold_q <= hold_q - 5'h01;
			end
			sir_rx_q <= !(sir_rx_i || hold_q != 5'h00);
		end
	end
endmodule

`default_nettype wire

// ==== core/sast_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sast_defs.vh"

// Notes on behaviour
// - Async up to clk/16, sync up to clk/8
// - Transmitter and receiver run independently
// - Seven, eight or nine data bits
// - Even, odd or no parity, generated and checked
// - One or two stop bits sent
// - LSB-first or MSB-first shifting
// - Parity, overrun and framing errors detected
// - RTS shows room, CTS gates transmit
// - IrDA SIR encoder and decoder option
// - RS485 enable active while transmitting
// - Eight-deep transmit and receive queues
// - Four interrupt kinds raised
// - Status flags readable by software
module sast_top (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire mode_sync_i,
	input wire [15:0] baud_div_i,
	input wire [1:0] word_len_i,
	input wire parity_en_i,
	input wire parity_odd_i,
	input wire stop_two_i,
	input wire msb_first_i,
	input wire flow_ctl_en_i,
	input wire irda_en_i,
	input wire rs485_en_i,
	input wire [3:0] rx_thresh_i,
	input wire [7:0] timeout_bits_i,
	input wire [3:0] irq_en_i,
	input wire [4:0] status_clr_i,
	input wire [8:0] tx_data_i,
	input wire tx_valid_i,
	output reg tx_ready_o,
	output wire [8:0] rx_data_o,
	output reg rx_valid_o,
	input wire rx_pop_i,
	output reg [7:0] serial_status_flag_reg_o,
	output reg irq_line_o,
	output reg irq_tx_empty_o,
	output reg irq_rx_thresh_o,
	output reg irq_timeout_o,
	output reg txd_o,
	input wire rxd_i,
	output reg rts_n_o,
	input wire cts_n_i,
	output reg rs485_de_o,
	output reg sclk_o
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_START = 5'h02;
	localparam [4:0] ST_DATA = 5'h04;
	localparam [4:0] ST_PAR = 5'h08;
	localparam [4:0] ST_STOP = 5'h10;

	function [3:0] nbits;
		input [1:0] wl;
		begin
			nbits = (wl == `SAST_WL_7) ? 4'h7 : (wl == `SAST_WL_8) ? 4'h8 : 4'h9;
		end
	endfunction

	function [8:0] wmask;
		input [1:0] wl;
		begin
			wmask = (wl == `SAST_WL_7) ? 9'h07F : (wl == `SAST_WL_8) ? 9'h0FF : 9'h1FF;
		end
	endfunction

	function [3:0] bitpos;
		input [3:0] idx;
		input [3:0] n;
		input msb;
		begin
			bitpos = msb ? (n - 4'h1 - idx) : idx;
		end
	endfunction

	wire [3:0] nb = nbits(word_len_i);
	wire [8:0] msk = wmask(word_len_i);
	wire [3:0] tpb = mode_sync_i ? `SAST_TPB_SYNC : `SAST_TPB_ASYNC;
	wire [3:0] half = mode_sync_i ? `SAST_HALF_SYNC : `SAST_HALF_ASYNC;
	wire sir_on = irda_en_i && !mode_sync_i;

	// ----------------------------------------
	// Rate tick
	// ----------------------------------------
	reg [15:0] div_q;
	reg tick_q;
	// Rate divider
	// Bits last 16 ticks async and 8 ticks sync, so the ceilings follow
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == baud_div_i);
			div_q <= (div_q == baud_div_i) ? 16'h0000 : div_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// Queues
	// ----------------------------------------
	wire [8:0] txf_dout;
	wire [3:0] txf_cnt;
	wire txf_full;
	wire txf_empty;
	wire [3:0] rxf_cnt;
	wire rxf_full;
	wire rxf_empty;
	reg tx_pop;
	reg rx_push;
	reg [8:0] rx_word;

	sast_fifo u_txf (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.push_i(tx_valid_i),
		.din_i(tx_data_i),
		.pop_i(tx_pop),
		.dout_q(txf_dout),
		.count_q(txf_cnt),
		.full_q(txf_full),
		.empty_q(txf_empty)
	);

	sast_fifo u_rxf (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.push_i(rx_push),
		.din_i(rx_word),
		.pop_i(rx_pop_i),
		.dout_q(rx_data_o),
		.count_q(rxf_cnt),
		.full_q(rxf_full),
		.empty_q(rxf_empty)
	);

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	reg [4:0] tx_st_q;
	reg [8:0] tx_sh_q;
	reg [3:0] tx_idx_q;
	reg [3:0] tx_cnt_q;
	reg tx_line_q;
	reg tx_stop2_q;
	wire tx_end = tick_q && (tx_cnt_q == tpb);
	// Clear to send gates each new frame
	wire tx_go = !txf_empty && !(flow_ctl_en_i && cts_n_i);

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tx_st_q <= ST_IDLE;
			tx_sh_q <= 9'h000;
			tx_idx_q <= 4'h0;
			tx_cnt_q <= 4'h0;
			tx_line_q <= 1'b1;
			tx_stop2_q <= 1'b0;
			tx_pop <= 1'b0;
		end else begin
			tx_pop <= 1'b0;
			if (tick_q && tx_st_q != ST_IDLE) begin
				tx_cnt_q <= tx_end ? 4'h0 : tx_cnt_q + 4'h1;
			end
			case (tx_st_q)
				ST_IDLE: begin
					tx_line_q <= 1'b1;
					if (tx_go && tick_q && !tx_pop) begin
						tx_sh_q <= txf_dout & msk;
						tx_pop <= 1'b1;
						tx_cnt_q <= 4'h0;
						tx_line_q <= 1'b0;
						tx_st_q <= ST_START;
					end
				end
				ST_START: begin
					if (tx_end) begin
						tx_idx_q <= 4'h0;
						tx_line_q <= tx_sh_q[bitpos(4'h0, nb, msb_first_i)];
						tx_st_q <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (tx_end) begin
						if (tx_idx_q == nb - 4'h1) begin
							tx_line_q <= parity_en_i ? (^tx_sh_q) ^ parity_odd_i : 1'b1;
							tx_stop2_q <= stop_two_i;
							tx_st_q <= parity_en_i ? ST_PAR : ST_STOP;
						end else begin
							tx_idx_q <= tx_idx_q + 4'h1;
							tx_line_q <= tx_sh_q[bitpos(tx_idx_q + 4'h1, nb, msb_first_i)];
						end
					end
				end
				ST_PAR: begin
					if (tx_end) begin
						tx_line_q <= 1'b1;
						tx_st_q <= ST_STOP;
					end
				end
				default: begin
					if (tx_end) begin
						if (tx_stop2_q) begin
							tx_stop2_q <= 1'b0;
						end else begin
							tx_st_q <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Line coding and pins
	// ----------------------------------------
	wire sir_tx;
	wire sir_rx;

	sast_sir u_sir (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_q),
		.tx_bit_i(tx_line_q),
		.tx_phase_i(tx_cnt_q),
		.sir_rx_i(rxd_i && sir_on),
		.sir_tx_q(sir_tx),
		.sir_rx_q(sir_rx)
	);

	wire rx_in = sir_on ? sir_rx : rxd_i;

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			txd_o <= 1'b1;
			rs485_de_o <= 1'b0;
			sclk_o <= 1'b1;
			rts_n_o <= 1'b1;
		end else begin
			txd_o <= sir_on ? sir_tx : tx_line_q;
			rs485_de_o <= rs485_en_i && (tx_st_q != ST_IDLE);
			// Clock low in first half so the partner samples on the rising edge
			sclk_o <= !(mode_sync_i && tx_st_q != ST_IDLE && tx_st_q != ST_START
				&& tx_cnt_q <= `SAST_HALF_SYNC);
			// Ready to receive while fewer than seven words are queued
			rts_n_o <= flow_ctl_en_i && (rxf_cnt >= `SAST_RTS_LIMIT);
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	reg [4:0] rx_st_q;
	reg [8:0] rx_sh_q;
	reg [3:0] rx_idx_q;
	reg [3:0] rx_cnt_q;
	reg rx_par_q;
	reg rx_zero_q;
	reg rx_arm_q;
	reg ev_par;
	reg ev_frm;
	reg ev_ovr;
	reg ev_brk;
	wire rx_end = tick_q && (rx_cnt_q == tpb);

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rx_st_q <= ST_IDLE;
			rx_sh_q <= 9'h000;
			rx_idx_q <= 4'h0;
			rx_cnt_q <= 4'h0;
			rx_par_q <= 1'b0;
			rx_zero_q <= 1'b0;
			rx_arm_q <= 1'b0;
			rx_push <= 1'b0;
			rx_word <= 9'h000;
			{ev_par, ev_frm, ev_ovr, ev_brk} <= 4'h0;
		end else begin
			rx_push <= 1'b0;
			{ev_par, ev_frm, ev_ovr, ev_brk} <= 4'h0;
			if (tick_q && rx_st_q != ST_IDLE) begin
				rx_cnt_q <= rx_end ? 4'h0 : rx_cnt_q + 4'h1;
			end
			case (rx_st_q)
				ST_IDLE: begin
					// Rearm only after the line has been high, so a break starts no frame
					if (rx_in) begin
						rx_arm_q <= 1'b1;
					end else if (tick_q && rx_arm_q) begin
						rx_arm_q <= 1'b0;
						rx_cnt_q <= 4'h0;
						rx_st_q <= ST_START;
					end
				end
				ST_START: begin
					if (tick_q && rx_cnt_q == half) begin
						rx_cnt_q <= 4'h0;
						rx_idx_q <= 4'h0;
						rx_sh_q <= 9'h000;
						rx_zero_q <= 1'b1;
						rx_st_q <= rx_in ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (rx_end) begin
						rx_sh_q[bitpos(rx_idx_q, nb, msb_first_i)] <= rx_in;
						rx_zero_q <= rx_zero_q && !rx_in;
						rx_idx_q <= rx_idx_q + 4'h1;
						if (rx_idx_q == nb - 4'h1) begin
							rx_st_q <= parity_en_i ? ST_PAR : ST_STOP;
						end
					end
				end
				ST_PAR: begin
					if (rx_end) begin
						rx_par_q <= rx_in;
						rx_zero_q <= rx_zero_q && !rx_in;
						rx_st_q <= ST_STOP;
					end
				end
				default: begin
					if (rx_end) begin
						rx_st_q <= ST_IDLE;
						if (rx_zero_q && !rx_in) begin
							ev_brk <= 1'b1;
							ev_frm <= 1'b1;
						end else begin
							ev_frm <= !rx_in;
							ev_par <= parity_en_i && (rx_par_q != ((^rx_sh_q) ^ parity_odd_i));
							ev_ovr <= rxf_full;
							rx_push <= !rxf_full;
							rx_word <= rx_sh_q;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Receive timeout
	// ----------------------------------------
	reg [3:0] tmo_tick_q;
	reg [7:0] tmo_bits_q;
	reg ev_tmo;
	// Idle bit periods counted while data waits
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tmo_tick_q <= 4'h0;
			tmo_bits_q <= 8'h00;
			ev_tmo <= 1'b0;
		end else begin
			ev_tmo <= 1'b0;
			if (rxf_empty || rx_push || rx_pop_i || rx_st_q != ST_IDLE) begin
				tmo_tick_q <= 4'h0;
				tmo_bits_q <= 8'h00;
			end else if (tick_q) begin
				tmo_tick_q <= (tmo_tick_q == tpb) ? 4'h0 : tmo_tick_q + 4'h1;
				if (tmo_tick_q == tpb && tmo_bits_q != timeout_bits_i) begin
					tmo_bits_q <= tmo_bits_q + 8'h01;
					ev_tmo <= (tmo_bits_q + 8'h01 == timeout_bits_i);
				end
			end
		end
	end

	// ----------------------------------------
	// Status and interrupts
	// ----------------------------------------
	reg [4:0] sticky_q;
	wire [4:0] ev_all = {ev_tmo, ev_brk, ev_ovr, ev_frm, ev_par};
	wire rxt_lvl = !rxf_empty && (rxf_cnt >= rx_thresh_i);

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sticky_q <= 5'h00;
			serial_status_flag_reg_o <= 8'h00;
			irq_line_o <= 1'b0;
			irq_tx_empty_o <= 1'b0;
			irq_rx_thresh_o <= 1'b0;
			irq_timeout_o <= 1'b0;
			tx_ready_o <= 1'b0;
			rx_valid_o <= 1'b0;
		end else begin
			// Sticky flags; a new event beats a clear
			sticky_q <= (sticky_q & ~status_clr_i) | ev_all;
			serial_status_flag_reg_o <= {tx_st_q != ST_IDLE, rxt_lvl, txf_empty, sticky_q};
			irq_line_o <= irq_en_i[0] && (sticky_q[3:0] != 4'h0);
			irq_tx_empty_o <= irq_en_i[1] && txf_empty;
			irq_rx_thresh_o <= irq_en_i[2] && rxt_lvl;
			irq_timeout_o <= irq_en_i[3] && sticky_q[`SAST_SF_TMO];
			tx_ready_o <= !txf_full && !(tx_valid_i && txf_cnt == `SAST_DEPTH - 4'h1);
			rx_valid_o <= !rxf_empty && !(rx_pop_i && rxf_cnt == 4'h1);
		end
	end
endmodule

`default_nettype wire

// ==== tb/sast_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module sast_top_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic mode_sync_i,
	input wire logic flow_ctl_en_i,
	input wire logic irda_en_i,
	input wire logic rs485_en_i,
	input wire logic cts_n_i,
	input wire logic tx_ready_o,
	input wire logic rx_valid_o,
	input wire logic [7:0] serial_status_flag_reg_o,
	input wire logic irq_line_o,
	input wire logic irq_timeout_o,
	input wire logic txd_o,
	input wire logic rts_n_o,
	input wire logic rs485_de_o,
	input wire logic sclk_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	a_rts_room: assert property ((!rx_valid_o || !flow_ctl_en_i) [*3] |-> !rts_n_o)
		else $error("rts raised with room");
	a_cts_hold: assert property ((flow_ctl_en_i && cts_n_i && rs485_en_i && !rs485_de_o) [*6]
		|=> !rs485_de_o)
		else $error("frame started while cts off");
	a_de_off: assert property (!rs485_en_i |=> !rs485_de_o)
		else $error("de high while rs485 off");
	a_de_frame: assert property (rs485_en_i && !irda_en_i && !mode_sync_i && $fell(txd_o)
		|-> rs485_de_o)
		else $error("line driven without de");
	a_sclk_idle: assert property ((!mode_sync_i) [*3] |-> sclk_o)
		else $error("sclk moves in async mode");
	a_ready_rst: assert property ($rose(rst_n_i) |=> tx_ready_o)
		else $error("tx queue not ready after reset");
	a_empty_ready: assert property (serial_status_flag_reg_o[5] |-> tx_ready_o)
		else $error("empty tx queue refuses");
	a_line_irq: assert property ($rose(irq_line_o) |-> ##[0:2] |serial_status_flag_reg_o[3:0])
		else $error("line irq without error flag");
	a_tmo_irq: assert property ($rose(irq_timeout_o) |-> ##[0:2] serial_status_flag_reg_o[4])
		else $error("timeout irq without flag");
	c_rx: cover property ($rose(rx_valid_o));
	c_rts: cover property ($rose(rts_n_o));
	c_line: cover property ($rose(irq_line_o));
endmodule
bind sast_top sast_top_chk u_chk (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mode_sync_i(mode_sync_i),
	.flow_ctl_en_i(flow_ctl_en_i), .irda_en_i(irda_en_i), .rs485_en_i(rs485_en_i),
	.cts_n_i(cts_n_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
	.serial_status_flag_reg_o(serial_status_flag_reg_o), .irq_line_o(irq_line_o),
	.irq_timeout_o(irq_timeout_o), .txd_o(txd_o), .rts_n_o(rts_n_o),
	.rs485_de_o(rs485_de_o), .sclk_o(sclk_o)
);
`default_nettype wire

// ==== tb/sast_station.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Remote station, 16 clocks a bit
// ----------------------------------------
module sast_station (
	input wire logic clk_sys_i,
	input wire logic txd_i,
	input wire logic rts_n_i,
	output logic rxd_o,
	output logic cts_n_o
);
	initial begin
		rxd_o = 1'b1;
		cts_n_o = 1'b0;
	end
	task automatic hold(input logic h);
		@(posedge clk_sys_i);
		cts_n_o <= h;
	endtask
	task automatic send(input logic [12:0] bits, input int n);
		int i;
		while (rts_n_i)
			@(posedge clk_sys_i);
		@(posedge clk_sys_i);
		rxd_o <= 1'b0;
		repeat (16) @(posedge clk_sys_i);
		for (i = 0; i < n; i++) begin
			rxd_o <= bits[i];
			repeat (16) @(posedge clk_sys_i);
		end
		rxd_o <= 1'b1;
	endtask
	// Unsampled positions read as ones, like trailing idle line
	task automatic recv(input int n, output logic [12:0] bits);
		int i;
		bits = '1;
		@(negedge txd_i);
		repeat (8) @(posedge clk_sys_i);
		for (i = 0; i < n; i++) begin
			repeat (16) @(posedge clk_sys_i);
			bits[i] = txd_i;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/sast_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sast_top_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [5:0] cf = 6'h01;
	logic [3:0] ctl = 4'h0;
	logic [7:0] tmo = 8'h00;
	logic [4:0] clr = 5'h00;
	logic [8:0] tx_data_i = 9'h000;
	logic tx_valid_i = 1'b0;
	logic rx_pop_i = 1'b0;
	logic [12:0] got;
	logic [5:0] cases [6] = '{6'h01, 6'h04, 6'h1E, 6'h35, 6'h30, 6'h0F};
	int checks = 0;
	int n_errors = 0;
	int i, k;
	wire tx_ready_o, rx_valid_o, irq_line_o, irq_tx_empty_o, irq_rx_thresh_o, irq_timeout_o;
	wire txd_o, rts_n_o, rs485_de_o, sclk_o, rxd, cts_n;
	wire [8:0] rx_data_o;
	wire [7:0] serial_status_flag_reg_o;
	always #2.5 clk_sys_i = ~clk_sys_i;
	sast_top dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mode_sync_i(ctl[0]), .baud_div_i(16'h0000),
		.word_len_i(cf[1:0]), .parity_en_i(cf[2]), .parity_odd_i(cf[3]), .stop_two_i(cf[4]),
		.msb_first_i(cf[5]), .flow_ctl_en_i(ctl[1]), .irda_en_i(ctl[2]), .rs485_en_i(ctl[3]),
		.rx_thresh_i(4'h4), .timeout_bits_i(tmo), .irq_en_i(4'hF), .status_clr_i(clr),
		.tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
		.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_pop_i(rx_pop_i),
		.serial_status_flag_reg_o(serial_status_flag_reg_o), .irq_line_o(irq_line_o),
		.irq_tx_empty_o(irq_tx_empty_o), .irq_rx_thresh_o(irq_rx_thresh_o),
		.irq_timeout_o(irq_timeout_o), .txd_o(txd_o), .rxd_i(rxd), .rts_n_o(rts_n_o),
		.cts_n_i(cts_n), .rs485_de_o(rs485_de_o), .sclk_o(sclk_o)
	);
	sast_station st (.clk_sys_i(clk_sys_i), .txd_i(txd_o), .rts_n_i(rts_n_o), .rxd_o(rxd),
		.cts_n_o(cts_n));
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic int dbits(input logic [5:0] c);
		return (c[1:0] == 2'h0) ? 7 : (c[1:0] == 2'h1) ? 8 : 9;
	endfunction
	// Line-order bits after the start bit; stops stay at one
	function automatic logic [12:0] frame(input logic [8:0] d, input logic [5:0] c);
		logic [12:0] f;
		logic p;
		int j, nb;
		nb = dbits(c);
		f = '1;
		p = c[3];
		for (j = 0; j < nb; j++) begin
			f[j] = c[5] ? d[nb - 1 - j] : d[j];
			p = p ^ d[j];
		end
		if (c[2])
			f[nb] = p;
		return f;
	endfunction
	task automatic do_reset;
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic push(input logic [8:0] d);
		@(posedge clk_sys_i);
		tx_data_i <= d;
		tx_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		tx_valid_i <= 1'b0;
	endtask
	task automatic pop(input logic [8:0] e);
		int w;
		// Let the previous pop settle before the head word is looked at
		@(posedge clk_sys_i);
		for (w = 0; w < 400 && rx_valid_o !== 1'b1; w++)
			@(posedge clk_sys_i);
		chk("rx_valid", rx_valid_o, 1'b1);
		chk("rx_data", rx_data_o, e);
		rx_pop_i <= 1'b1;
		@(posedge clk_sys_i);
		rx_pop_i <= 1'b0;
	endtask
	task automatic xfer(input logic [5:0] c, input logic [8:0] d);
		int n;
		logic [8:0] m;
		@(posedge clk_sys_i);
		cf <= c;
		n = dbits(c) + c[2] + 1 + c[4];
		m = 9'((1 << dbits(c)) - 1);
		fork
			push(d);
			st.recv(n, got);
			st.send(frame(~d, c), n);
		join
		chk("tx frame", got, frame(d, c));
		pop(~d & m);
	endtask
	task automatic line(input logic [12:0] f, input int n, input logic [4:0] e);
		st.send(f, n);
		repeat (6) @(posedge clk_sys_i);
		chk("error flags", serial_status_flag_reg_o[4:0], e);
		chk("irq line", irq_line_o, 1'b1);
		do_reset;
	endtask
	task automatic edges(input int cyc, input logic s, output int n);
		logic p, v;
		n = 0;
		p = s ? txd_o : ~sclk_o;
		repeat (cyc) begin
			@(posedge clk_sys_i);
			v = s ? txd_o : ~sclk_o;
			n += int'(v & ~p);
			p = v;
		end
	endtask
	initial begin
		#100000;
		n_errors++;
		complete_run;
	end
	initial begin
		do_reset;
		for (i = 0; i < 6; i++)
			xfer(cases[i], 9'h0B7 + 9'(i * 83));
		cf <= 6'h05;
		line(frame(9'h05A, 6'h05) ^ 13'h0100, 10, 5'h01);
		line(frame(9'h05A, 6'h05) ^ 13'h0200, 10, 5'h02);
		line(13'h0000, 13, 5'h0A);
		for (i = 0; i < 9; i++)
			st.send(frame(9'(i), 6'h05), 10);
		ctl <= 4'h2;
		repeat (6) @(posedge clk_sys_i);
		chk("overrun", serial_status_flag_reg_o[2], 1'b1);
		chk("rts", rts_n_o, 1'b1);
		chk("at thresh", serial_status_flag_reg_o[6], 1'b1);
		chk("irq rx", irq_rx_thresh_o, 1'b1);
		for (i = 0; i < 8; i++)
			pop(9'(i));
		do_reset;
		tmo <= 8'h02;
		st.send(frame(9'h033, 6'h05), 10);
		chk("early tmo", serial_status_flag_reg_o[4], 1'b0);
		repeat (60) @(posedge clk_sys_i);
		chk("tmo", serial_status_flag_reg_o[4], 1'b1);
		chk("irq tmo", irq_timeout_o, 1'b1);
		clr <= 5'h10;
		@(posedge clk_sys_i);
		clr <= 5'h00;
		repeat (3) @(posedge clk_sys_i);
		chk("tmo clr", serial_status_flag_reg_o[4], 1'b0);
		tmo <= 8'h00;
		do_reset;
		cf <= 6'h01;
		ctl <= 4'hA;
		st.hold(1'b1);
		for (i = 0; i < 9; i++)
			push(9'(i + 16));
		repeat (4) @(posedge clk_sys_i);
		chk("ready full", tx_ready_o, 1'b0);
		chk("held idle", txd_o, 1'b1);
		st.hold(1'b0);
		for (i = 0; i < 8; i++) begin
			st.recv(9, got);
			chk("queued", got, frame(9'(i + 16), 6'h01));
			chk("de", rs485_de_o, 1'b1);
		end
		repeat (40) @(posedge clk_sys_i);
		chk("tx drained", serial_status_flag_reg_o[7:5], 3'h1);
		chk("irq tx empty", irq_tx_empty_o, 1'b1);
		ctl <= 4'h4;
		push(9'h000);
		edges(200, 1'b1, k);
		chk("sir pulses", 13'(k), 13'h9);
		ctl <= 4'h1;
		push(9'h0A5);
		edges(120, 1'b0, k);
		chk("sclk pulses", 13'(k), 13'h9);
		complete_run;
	end
endmodule
`default_nettype wire
